// ---- hdl/bllk_cfg.svh ----
// constants for the banded lba lock and key control block
`ifndef BLLK_CFG_SVH
`define BLLK_CFG_SVH
`define BLLK_OP_SEC_OUT   8'hB5
`define BLLK_OP_SEC_IN    8'hA2
`define BLLK_OP_SANITIZE  8'h48
`define BLLK_SA_CRYPTO    5'h03
`define BLLK_GLOBAL_BAND  4'h0
`define BLLK_ALIGN_MASK   48'h0000_0000_0007
`endif

// ---- hdl/bllk_pkg.sv ----
// types for the banded lba lock and key control block
package bllk_pkg;
  typedef enum logic [3:0] {
    BLLK_C_NOP       = 4'b0000,
    BLLK_C_SET_CRED  = 4'b0001,
    BLLK_C_ENABLE    = 4'b0010,
    BLLK_C_ALLOC     = 4'b0011,
    BLLK_C_UNLOCK    = 4'b0100,
    BLLK_C_SET_POL   = 4'b0101,
    BLLK_C_ERASE     = 4'b0110,
    BLLK_C_REVERT    = 4'b0111,
    BLLK_C_FW_LOCK   = 4'b1000,
    BLLK_C_RANDOM    = 4'b1001,
    BLLK_C_OWNER     = 4'b1010
  } bllk_cmd_e;
  typedef enum logic [1:0] {
    BLLK_ST_IDLE  = 2'b00,
    BLLK_ST_SCAN  = 2'b01,
    BLLK_ST_ERASE = 2'b10
  } bllk_state_e;
endpackage : bllk_pkg

// ---- hdl/bllk_top.sv ----
// banded lba lock and key control top
`include "bllk_cfg.svh"
module bllk_top #(
  parameter int NB   = 16,
  parameter int LW   = 48,
  parameter int KW   = 256,
  parameter logic [47:0] MAX_LBA = 48'h0000_FFFF_FFFF,
  parameter logic [255:0] FACTORY_CRED = 256'h5A5A_A5A5 // arbitrary value
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // security command port
  input  wire logic              cmd_valid,
  input  wire bllk_pkg::bllk_cmd_e cmd_code,
  input  wire logic [3:0]        cmd_band,
  input  wire logic [KW-1:0]     cmd_cred,
  input  wire logic [KW-1:0]     cmd_new_cred,
  input  wire logic [LW-1:0]     cmd_start,
  input  wire logic [LW-1:0]     cmd_len,
  input  wire logic [3:0]        cmd_policy,
  input  wire logic [7:0]        cmd_opcode,
  input  wire logic [4:0]        cmd_sa,
  input  wire logic [KW-1:0]     label_cred,
  output logic                   cmd_done,
  output logic                   cmd_ok,
  output logic [KW-1:0]          cmd_rdata,
  // media access request
  input  wire logic              io_valid,
  input  wire logic [LW-1:0]     io_lba,
  output logic                   io_done,
  output logic                   io_grant,
  output logic [3:0]             io_band,
  output logic [KW-1:0]          io_key,
  // firmware download checks
  input  wire logic              fw_valid,
  input  wire logic              fw_is_sed,
  input  wire logic              fw_sig_ok,
  input  wire logic              fw_accept_ok,
  output logic                   fw_done,
  output logic                   fw_ok,
  output logic                   fw_locked,
  // power loss event and random source
  input  wire logic              power_loss_event,
  input  wire logic [KW-1:0]     rnd_in
);
  import bllk_pkg::*;

  // ------------------------------------------------------------
  // band table
  // ------------------------------------------------------------
  logic [LW-1:0] b_start_r [NB];
  logic [LW-1:0] b_end_r   [NB];
  logic [NB-1:0] b_alloc_r, b_en_r, b_lock_r, b_rla_r, b_wla_r, b_pol_r;
  logic [KW-1:0] b_key_r   [NB];
  logic [KW-1:0] b_cred_r  [NB];
  logic [KW-1:0] erase_cred_r, owner_cred_r, rnd_r;
  bllk_state_e   st_r;
  logic [4:0]    ecnt_r;

  // random source register, stirred each cycle
  always_ff @(posedge sys_clk) begin
    if (srst) rnd_r <= '0;
    else rnd_r <= {rnd_r[KW-2:0], rnd_r[KW-1]} ^ rnd_in;
  end

  // ------------------------------------------------------------
  // decode and checks
  // ------------------------------------------------------------
  wire [LW-1:0] new_end = cmd_start + cmd_len - LW'(1);
  wire          len_ok  = (cmd_len != '0) && (new_end <= MAX_LBA)
                          && (new_end >= cmd_start);
  logic [NB-1:0] ovl;
  always_comb begin
    ovl = '0;
    for (int i = 1; i < NB; i++)
      if (b_alloc_r[i] && i != int'(cmd_band) &&
          !(new_end < b_start_r[i] || cmd_start > b_end_r[i]))
        ovl[i] = 1'b1;
  end
  wire bo_ok   = cmd_cred == b_cred_r[cmd_band];
  wire er_ok   = cmd_cred == erase_cred_r;
  wire own_ok  = cmd_cred == owner_cred_r;
  wire lbl_ok  = cmd_cred == label_cred;
  wire en_ok   = (cmd_band == 4'h1) || b_en_r[cmd_band];
  wire nonglob = cmd_band != `BLLK_GLOBAL_BAND;
  wire sec_op  = (cmd_opcode == `BLLK_OP_SEC_OUT) ||
                 (cmd_opcode == `BLLK_OP_SEC_IN);
  wire san_op  = (cmd_opcode == `BLLK_OP_SANITIZE) &&
                 (cmd_sa == `BLLK_SA_CRYPTO);
  logic ok_c;
  always_comb begin
    unique case (cmd_code)
      BLLK_C_NOP:      ok_c = 1'b1;
      BLLK_C_SET_CRED: ok_c = bo_ok;
      BLLK_C_ENABLE:   ok_c = er_ok && nonglob;
      BLLK_C_ALLOC:    ok_c = bo_ok && nonglob && en_ok && len_ok
                              && (ovl == '0);
      BLLK_C_UNLOCK:   ok_c = bo_ok;
      BLLK_C_SET_POL:  ok_c = bo_ok;
      BLLK_C_ERASE:    ok_c = san_op ? er_ok : (bo_ok || er_ok);
      BLLK_C_REVERT:   ok_c = lbl_ok;
      BLLK_C_FW_LOCK:  ok_c = own_ok;
      BLLK_C_RANDOM:   ok_c = 1'b1;
      BLLK_C_OWNER:    ok_c = own_ok;
      default:         ok_c = 1'b0;
    endcase
  end
  wire cmd_go = cmd_valid && (st_r == BLLK_ST_IDLE) && (sec_op || san_op);

  // band lookup: highest allocated band containing lba, else global
  logic [3:0] hit_c;
  always_comb begin
    hit_c = `BLLK_GLOBAL_BAND;
    for (int i = 1; i < NB; i++)
      if (b_alloc_r[i] && io_lba >= b_start_r[i] && io_lba <= b_end_r[i])
        hit_c = 4'(i);
  end

  // ------------------------------------------------------------
  // band state and keys
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= BLLK_ST_IDLE;
      ecnt_r <= '0;
      b_alloc_r <= '0;
      b_en_r <= '0;
      b_lock_r <= '0;
      b_rla_r <= '0;
      b_wla_r <= '0;
      b_pol_r <= '0;
      erase_cred_r <= FACTORY_CRED;
      owner_cred_r <= FACTORY_CRED;
      fw_locked <= 1'b0;
      for (int i = 0; i < NB; i++) begin
        b_start_r[i] <= '0;
        b_end_r[i] <= (i == 0) ? MAX_LBA : '0;
        b_key_r[i] <= '0;
        b_cred_r[i] <= FACTORY_CRED;
      end
    end else begin
      if (power_loss_event)
        for (int i = 0; i < NB; i++)
          if (b_pol_r[i] && b_rla_r[i] && b_wla_r[i])
            b_lock_r[i] <= 1'b1;
      unique case (st_r)
        BLLK_ST_IDLE: if (cmd_go && ok_c) begin
          unique case (cmd_code)
            BLLK_C_SET_CRED: b_cred_r[cmd_band] <= cmd_new_cred;
            BLLK_C_ENABLE:   b_en_r[cmd_band] <= 1'b1;
            BLLK_C_ALLOC: begin
              b_alloc_r[cmd_band] <= 1'b1;
              b_start_r[cmd_band] <= cmd_start;
              b_end_r[cmd_band] <= new_end;
            end
            BLLK_C_UNLOCK:   if (!power_loss_event)
                               b_lock_r[cmd_band] <= 1'b0;
            BLLK_C_SET_POL: begin
              b_pol_r[cmd_band] <= cmd_policy[0];
              b_rla_r[cmd_band] <= cmd_policy[1];
              b_wla_r[cmd_band] <= cmd_policy[2];
              if (cmd_policy[3]) b_lock_r[cmd_band] <= 1'b1;
            end
            BLLK_C_ERASE:
              if (san_op) begin
                st_r <= BLLK_ST_ERASE;
                ecnt_r <= '0;
              end else b_key_r[cmd_band] <= rnd_r;
            BLLK_C_REVERT: begin
              st_r <= BLLK_ST_ERASE;
              ecnt_r <= '0;
              b_alloc_r <= '0;
              b_en_r <= '0;
              b_lock_r <= '0;
              b_pol_r <= '0;
              b_rla_r <= '0;
              b_wla_r <= '0;
              fw_locked <= 1'b0;
              erase_cred_r <= FACTORY_CRED;
              owner_cred_r <= FACTORY_CRED;
              for (int i = 0; i < NB; i++) b_cred_r[i] <= FACTORY_CRED;
              b_end_r[0] <= MAX_LBA;
            end
            BLLK_C_FW_LOCK:  fw_locked <= cmd_policy[0];
            BLLK_C_OWNER:    owner_cred_r <= cmd_new_cred;
            default: ;
          endcase
        end
        BLLK_ST_ERASE: begin
          b_key_r[ecnt_r[3:0]] <= rnd_r ^ {KW{ecnt_r[0]}};
          ecnt_r <= ecnt_r + 5'h01;
          if (ecnt_r == 5'(NB - 1)) st_r <= BLLK_ST_IDLE;
        end
        default: st_r <= BLLK_ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // answers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmd_done <= 1'b0;
      cmd_ok <= 1'b0;
      cmd_rdata <= '0;
      io_done <= 1'b0;
      io_grant <= 1'b0;
      io_band <= '0;
      io_key <= '0;
      fw_done <= 1'b0;
      fw_ok <= 1'b0;
    end else begin
      cmd_done <= cmd_go;
      cmd_ok <= cmd_go && ok_c;
      // label credential is never returned on this path
      cmd_rdata <= (cmd_go && cmd_code == BLLK_C_RANDOM) ? rnd_r : '0;
      io_done <= io_valid;
      io_grant <= io_valid && !b_lock_r[hit_c] &&
                  (st_r == BLLK_ST_IDLE);
      io_band <= hit_c;
      io_key <= io_valid ? b_key_r[hit_c] : '0;
      fw_done <= fw_valid;
      fw_ok <= fw_valid && !fw_locked && fw_is_sed && fw_sig_ok
               && fw_accept_ok;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_lock_refuse: assert property (io_valid && b_lock_r[hit_c]
    |=> io_done && !io_grant) else $error("locked band granted");
  a_fw_refuse: assert property (fw_valid && fw_locked |=> !fw_ok)
    else $error("fw accepted while locked");
  a_fw_type: assert property (fw_valid && !fw_is_sed |=> !fw_ok)
    else $error("non encrypting image accepted");
  a_fw_sig: assert property (fw_valid && !fw_sig_ok |=> !fw_ok)
    else $error("unsigned image accepted");
  a_fw_accept: assert property (fw_valid && !fw_accept_ok |=> !fw_ok)
    else $error("incompatible image accepted");
  a_cred_refuse: assert property (cmd_go && !ok_c |=> cmd_done && !cmd_ok)
    else $error("bad credential accepted");
  a_pwr_lock: assert property (power_loss_event && b_pol_r[1] && b_rla_r[1]
    && b_wla_r[1] |=> b_lock_r[1]) else $error("band not locked");
  a_erase_len: assert property ($rose(st_r == BLLK_ST_ERASE)
    |-> ##[15:16] st_r == BLLK_ST_IDLE) else $error("erase length");
  a_key_change: assert property (cmd_go && ok_c && cmd_code == BLLK_C_ERASE
    && !san_op |=> b_key_r[$past(cmd_band)] == $past(rnd_r))
    else $error("key not replaced");
  c_alloc: cover property (cmd_go && ok_c && cmd_code == BLLK_C_ALLOC);
  c_revert: cover property (cmd_go && ok_c && cmd_code == BLLK_C_REVERT);
  c_locked_io: cover property (io_valid && b_lock_r[hit_c]);
  c_fw_ok: cover property (fw_ok);
endmodule // bllk_top

// ---- testbench/bllk_host_model.sv ----
// host side model that issues security commands to the block
`include "bllk_cfg.svh"
module bllk_host_model (
  // clock
  input  wire logic           sys_clk,
  // command port toward the block
  output logic                cmd_valid,
  output bllk_pkg::bllk_cmd_e cmd_code,
  output logic [3:0]          cmd_band,
  output logic [255:0]        cmd_cred,
  output logic [255:0]        cmd_new_cred,
  output logic [47:0]         cmd_start,
  output logic [47:0]         cmd_len,
  output logic [3:0]          cmd_policy,
  output logic [7:0]          cmd_opcode,
  output logic [4:0]          cmd_sa,
  // answer from the block
  input  wire logic           cmd_done,
  input  wire logic           cmd_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  import bllk_pkg::*;

  // idle port values
  initial begin
    {cmd_valid, cmd_band, cmd_cred, cmd_new_cred} = '0;
    {cmd_start, cmd_len, cmd_policy, cmd_opcode, cmd_sa} = '0;
    cmd_code = BLLK_C_NOP;
  end

  // one command, held for one edge, answer awaited a few cycles
  task automatic send(input bllk_cmd_e c, input logic [3:0] b,
      input logic [255:0] cr, nc, input logic [47:0] s, l,
      input logic [3:0] p, input logic san, output logic ok,
      output bit got);
    int n;
    @(posedge sys_clk);
    cmd_valid    <= 1'b1;
    cmd_code     <= c;
    cmd_band     <= b;
    cmd_cred     <= cr;
    cmd_new_cred <= nc;
    cmd_start    <= s;
    cmd_len      <= l;
    cmd_policy   <= p;
    // random values come back on the security protocol in path
    cmd_opcode   <= san ? `BLLK_OP_SANITIZE :
                    (c == BLLK_C_RANDOM) ? `BLLK_OP_SEC_IN :
                    `BLLK_OP_SEC_OUT;
    cmd_sa       <= san ? `BLLK_SA_CRYPTO : 5'h00;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    cmd_cred  <= ~cr; // released lines no longer show the value
    cmd_band  <= ~b;
    got = 0;
    ok = 1'b0;
    for (n = 0; n < 4 && !got; n++) begin
      @(negedge sys_clk);
      if (cmd_done === 1'b1) begin
        got = 1;
        ok = cmd_ok;
      end
    end
  endtask
endmodule // bllk_host_model

// ---- testbench/tb_top.sv ----
// self-checking bench for the banded lba lock and key control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bllk_pkg::*;
  localparam logic [255:0] F = 256'h0F0F_3C3C; // arbitrary value
  localparam logic [255:0] N = 256'h0000_5A5A;
  localparam logic [255:0] W = 256'h0000_0001;
  localparam logic [255:0] L = 256'h7E7E_1818;
  logic sys_clk, srst, io_valid, fw_valid, fw_is_sed, fw_sig_ok;
  logic fw_accept_ok, power_loss_event;
  logic [47:0] io_lba;
  logic [255:0] label_cred, rnd_in, key, k0;
  wire cmd_valid, cmd_done, cmd_ok, io_done, io_grant, fw_done;
  wire fw_ok, fw_locked;
  bllk_cmd_e cmd_code;
  wire [3:0] cmd_band, cmd_policy, io_band;
  wire [255:0] cmd_cred, cmd_new_cred, cmd_rdata, io_key;
  wire [47:0] cmd_start, cmd_len;
  wire [7:0] cmd_opcode;
  wire [4:0] cmd_sa;
  int err_total, num_checks;

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  bllk_top #(.FACTORY_CRED(F)) i_bllk_top (
    .sys_clk(sys_clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_band(cmd_band), .cmd_cred(cmd_cred),
    .cmd_new_cred(cmd_new_cred), .cmd_start(cmd_start),
    .cmd_len(cmd_len), .cmd_policy(cmd_policy),
    .cmd_opcode(cmd_opcode), .cmd_sa(cmd_sa), .label_cred(label_cred),
    .cmd_done(cmd_done), .cmd_ok(cmd_ok), .cmd_rdata(cmd_rdata),
    .io_valid(io_valid), .io_lba(io_lba), .io_done(io_done),
    .io_grant(io_grant), .io_band(io_band), .io_key(io_key),
    .fw_valid(fw_valid), .fw_is_sed(fw_is_sed), .fw_sig_ok(fw_sig_ok),
    .fw_accept_ok(fw_accept_ok), .fw_done(fw_done), .fw_ok(fw_ok),
    .fw_locked(fw_locked), .power_loss_event(power_loss_event),
    .rnd_in(rnd_in));
  bllk_host_model i_bllk_host_model (.sys_clk(sys_clk),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_band(cmd_band),
    .cmd_cred(cmd_cred), .cmd_new_cred(cmd_new_cred),
    .cmd_start(cmd_start), .cmd_len(cmd_len), .cmd_policy(cmd_policy),
    .cmd_opcode(cmd_opcode), .cmd_sa(cmd_sa), .cmd_done(cmd_done),
    .cmd_ok(cmd_ok));

  // ----------------------------------------
  // compare, verdict and transfer tasks
  // ----------------------------------------
  task automatic chk(input logic [255:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmd(input bllk_cmd_e c, input logic [3:0] b,
      input logic [255:0] cr, nc, input logic [47:0] s, l,
      input logic [3:0] p, input logic san, e);
    logic ok;
    bit got;
    i_bllk_host_model.send(c, b, cr, nc, s, l, p, san, ok, got);
    if (!got) begin
      err_total++;
      give_verdict;
    end else chk(ok, e);
  endtask
  task automatic io(input logic [47:0] a, input logic g, input [3:0] b);
    int n;
    @(posedge sys_clk);
    io_valid <= 1'b1;
    io_lba   <= a;
    @(posedge sys_clk);
    io_valid <= 1'b0;
    io_lba   <= ~a;
    // answers are looked at on the falling edge, never at the launch edge
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (io_done !== 1'b1 && n < 4);
    if (io_done !== 1'b1) begin
      err_total++;
      give_verdict;
    end else begin
      chk(io_grant, g);
      if (g) chk(io_band, b);
      key = io_key;
    end
  endtask
  task automatic fw(input logic s, g, a, e);
    int n;
    @(posedge sys_clk);
    fw_valid <= 1'b1;
    {fw_is_sed, fw_sig_ok, fw_accept_ok} <= {s, g, a};
    @(posedge sys_clk);
    fw_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (fw_done !== 1'b1 && n < 4);
    if (fw_done !== 1'b1) begin
      err_total++;
      give_verdict;
    end else chk(fw_ok, e);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_bands;
    io(48'h0, 1, 0);
    io(48'h0000_FFFF_FFFF, 1, 0);
    cmd(BLLK_C_ALLOC, 1, F, 0, 48'h1000, 48'h1000, 0, 0, 1);
    io(48'h1800, 1, 1);
    cmd(BLLK_C_ALLOC, 2, F, 0, 48'h2000, 48'h1000, 0, 0, 0);
    cmd(BLLK_C_ENABLE, 2, F, 0, 0, 0, 0, 0, 1);
    cmd(BLLK_C_ALLOC, 2, F, 0, 48'h2000, 48'h1000, 0, 0, 1);
    io(48'h2000, 1, 2);
    cmd(BLLK_C_ENABLE, 3, F, 0, 0, 0, 0, 0, 1);
    cmd(BLLK_C_ALLOC, 3, F, 0, 48'h2800, 48'h1000, 0, 0, 0);
    cmd(BLLK_C_ENABLE, 4, W, 0, 0, 0, 0, 0, 0);
    cmd(BLLK_C_RANDOM, 0, F, 0, 0, 0, 0, 0, 1);
    k0 = cmd_rdata;
    chk(k0 !== '0, 1);
    cmd(BLLK_C_RANDOM, 0, F, 0, 0, 0, 0, 0, 1);
    chk(cmd_rdata !== k0, 1);
  endtask
  task automatic sc_lock;
    cmd(BLLK_C_SET_POL, 1, F, 0, 0, 0, 4'h7, 0, 1);
    cmd(BLLK_C_SET_POL, 2, F, 0, 0, 0, 4'h3, 0, 1);
    @(posedge sys_clk) power_loss_event <= 1'b1;
    @(posedge sys_clk) power_loss_event <= 1'b0;
    io(48'h1800, 0, 1);
    io(48'h2000, 1, 2);
    cmd(BLLK_C_SET_CRED, 1, F, N, 0, 0, 0, 0, 1);
    cmd(BLLK_C_UNLOCK, 1, F, 0, 0, 0, 0, 0, 0);
    io(48'h1800, 0, 1);
    cmd(BLLK_C_UNLOCK, 1, N, 0, 0, 0, 0, 0, 1);
    io(48'h1800, 1, 1);
    cmd(BLLK_C_SET_POL, 2, F, 0, 0, 0, 4'h8, 0, 1);
    io(48'h2000, 0, 2);
  endtask
  task automatic sc_erase;
    k0 = key;
    @(posedge sys_clk) rnd_in <= 256'h0F1E_2D3C;
    cmd(BLLK_C_ERASE, 1, N, 0, 0, 0, 0, 0, 1);
    io(48'h1800, 1, 1);
    chk(key !== k0, 1);
    io(48'h0, 1, 0);
    k0 = key;
    @(posedge sys_clk) rnd_in <= 256'h4B4B_7171;
    cmd(BLLK_C_ERASE, 0, F, 0, 0, 0, 0, 1, 1);
    io(48'h0, 0, 0);
    repeat (20) @(posedge sys_clk);
    io(48'h0, 1, 0);
    chk(key !== k0, 1);
  endtask
  task automatic sc_fw;
    fw(1, 1, 1, 1);
    fw(0, 1, 1, 0);
    fw(1, 0, 1, 0);
    fw(1, 1, 0, 0);
    cmd(BLLK_C_FW_LOCK, 0, W, 0, 0, 0, 4'h1, 0, 0);
    cmd(BLLK_C_FW_LOCK, 0, F, 0, 0, 0, 4'h1, 0, 1);
    chk(fw_locked, 1);
    fw(1, 1, 1, 0);
    cmd(BLLK_C_OWNER, 0, F, N, 0, 0, 0, 0, 1);
    cmd(BLLK_C_FW_LOCK, 0, F, 0, 0, 0, 4'h0, 0, 0);
    chk(fw_locked, 1);
  endtask
  task automatic sc_revert;
    cmd(BLLK_C_REVERT, 0, F, 0, 0, 0, 0, 0, 0);
    cmd(BLLK_C_REVERT, 0, L, 0, 0, 0, 0, 0, 1);
    repeat (20) @(posedge sys_clk);
    io(48'h1800, 1, 0);
    chk(fw_locked, 0);
    cmd(BLLK_C_SET_CRED, 1, F, N, 0, 0, 0, 0, 1);
    cmd(BLLK_C_FW_LOCK, 0, F, 0, 0, 0, 4'h0, 0, 1);
    cmd(BLLK_C_RANDOM, 0, F, 0, 0, 0, 0, 0, 1);
    chk(cmd_rdata !== L, 1);
  endtask

  // main sequence
  initial begin
    {sys_clk, io_valid, io_lba, fw_valid, power_loss_event} = '0;
    {fw_is_sed, fw_sig_ok, fw_accept_ok} = '0;
    {err_total, num_checks} = '0;
    srst = 1'b1;
    label_cred = L;
    rnd_in = 256'hC3C3_9696;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    chk(fw_locked, 0);
    sc_bands;
    sc_lock;
    sc_erase;
    sc_fw;
    sc_revert;
    give_verdict;
  end
endmodule // tb_top
